// ===== bench/cic_charger_i2c_control_bench.sv
/* self-checking bench for the charger control port.
   assumes cic_host_model as bus master and an ideal sda pull-up. */
`timescale 1ns/1ns
module cic_charger_i2c_control_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic batt_low_i = 1'b0;
   logic scl, sda_pull, sda, sda_o, sda_oe, ak;
   logic charge_en, boost_en, hiz_en, input_voltage_floor_en;
   logic wake_current_en;
   logic [2:0] input_voltage_floor, chg_current_code;
   logic [7:0] rb, b;
   logic [31:0] seed = 32'h0000002d;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int regs [32];
   always #2 clk = ~clk;
   // pull-up wins unless either side pulls the line low
   assign sda = (sda_oe ? sda_o : 1'b1) & !sda_pull;
   cic_charger_i2c_control cic_charger_i2c_control_i (.clk(clk),
      .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .batt_low_i(batt_low_i), .charge_en(charge_en),
      .boost_en(boost_en), .hiz_en(hiz_en),
      .input_voltage_floor(input_voltage_floor),
      .input_voltage_floor_en(input_voltage_floor_en),
      .chg_current_code(chg_current_code),
      .wake_current_en(wake_current_en));
   cic_host_model cic_host_model_i (.clk(clk), .sda(sda), .scl(scl),
      .sda_pull(sda_pull));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic outs();
      logic [7:0] m, f, c;
      m = 8'(regs[0]);
      f = 8'(regs[17]);
      c = 8'(regs[6]);
      check({7'h0, hiz_en}, {7'h0, m[1]});
      check({7'h0, boost_en}, {7'h0, m[0] & !m[1]});
      check({7'h0, charge_en}, {7'h0, !m[0] & !m[1]});
      check({5'h0, input_voltage_floor},
         (f[2:0] == 3'h7) ? 8'h06 : {5'h0, f[2:0]});
      check({7'h0, input_voltage_floor_en}, {7'h0, f[3]});
      check({5'h0, chg_current_code}, {5'h0, c[6:4]});
      check({7'h0, wake_current_en},
         {7'h0, batt_low_i & !m[0] & !m[1]});
   endtask : outs
   task automatic send(input logic [7:0] d, input logic ok);
      // ninth bit released, so only the port can pull it low
      cic_host_model_i.xfer(d, 1'b1, rb, ak);
      check({7'h0, ak}, {7'h0, ok});
   endtask : send
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      cic_host_model_i.start();
      send({cic_pkg::DEV_ADDR, 1'b0}, 1'b1);
      send(idx, 1'b1);
      send(d, 1'b1);
      cic_host_model_i.stop();
      if (idx < 8'h20) regs[idx] = int'(d);
      repeat (4) @(posedge clk);
      #1;
      outs();
   endtask : wr
   // fresh index write, then a repeated start to read one byte
   task automatic rd(input logic [7:0] idx);
      cic_host_model_i.start();
      send({cic_pkg::DEV_ADDR, 1'b0}, 1'b1);
      send(idx, 1'b1);
      cic_host_model_i.start();
      send({cic_pkg::DEV_ADDR, 1'b1}, 1'b1);
      cic_host_model_i.xfer(8'hff, 1'b1, rb, ak);
      cic_host_model_i.stop();
      check(rb, (idx < 8'h20) ? 8'(regs[idx]) : 8'h00);
   endtask : rd
   task automatic close_out();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      foreach (regs[i]) regs[i] = 0;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      outs();
      // a foreign address must go unanswered
      cic_host_model_i.start();
      send({7'h2a, 1'b0}, 1'b0);
      cic_host_model_i.stop();
      outs();
      for (int k = 0; k < 8; k++) begin
         b = rnd();
         wr(8'h11, {b[7:3], 3'(k)});
      end
      for (int k = 0; k < 8; k++) begin
         batt_low_i = k[2];
         wr(8'h00, {6'h0, 2'(k)});
      end
      for (int k = 0; k < 3; k++) wr(8'h06, rnd());
      rd(8'h11);
      rd(8'h06);
      b = rnd();
      wr({3'h0, b[4:0]}, rnd());
      rd({3'h0, b[4:0]});
      // out of range index is acked, dropped and reads as zero
      wr(8'h25, 8'h5a);
      rd(8'h25);
      // two-byte burst from 0x10, read back with a master ack between
      cic_host_model_i.start();
      send({cic_pkg::DEV_ADDR, 1'b0}, 1'b1);
      send(8'h10, 1'b1);
      for (int k = 16; k < 18; k++) begin
         b = rnd();
         regs[k] = int'(b);
         send(b, 1'b1);
      end
      cic_host_model_i.stop();
      repeat (4) @(posedge clk);
      #1;
      outs();
      cic_host_model_i.start();
      send({cic_pkg::DEV_ADDR, 1'b0}, 1'b1);
      send(8'h10, 1'b1);
      cic_host_model_i.start();
      send({cic_pkg::DEV_ADDR, 1'b1}, 1'b1);
      cic_host_model_i.xfer(8'hff, 1'b0, rb, ak);
      check(rb, 8'(regs[16]));
      cic_host_model_i.xfer(8'hff, 1'b1, rb, ak);
      check(rb, 8'(regs[17]));
      cic_host_model_i.stop();
      close_out();
   end
endmodule : cic_charger_i2c_control_bench

// ===== bench/cic_host_model.sv
/* bus master model standing in for the host processor.
   assumes the bench resolves sda from both pull-downs and a pull-up. */
`timescale 1ns/1ns
module cic_host_model (
   // clock
   input wire logic clk,
   // resolved data level
   input wire logic sda,
   // bus clock and data pull-down
   output logic scl,
   output logic sda_pull
);
   // quarter bit, roomy against the port's input filter delay
   localparam int QTR = 8;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic tick();
      repeat (QTR) @(posedge clk);
      #1;
   endtask : tick
   // sda falls while scl is high, also as a repeated start
   task automatic start();
      sda_pull = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_pull = 1'b1;
      tick();
      scl = 1'b0;
      tick();
   endtask : start
   task automatic stop();
      sda_pull = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_pull = 1'b0;
      tick();
   endtask : stop
   // eight bits msb first, then the ninth; ack is a low ninth bit
   task automatic xfer(input logic [7:0] d, input logic nack,
      output logic [7:0] r, output logic ack);
      logic [8:0] o;
      o = {d, nack};
      r = 8'h00;
      ack = 1'b0;
      for (int i = 8; i >= 0; i--) begin
         sda_pull = !o[i];
         tick();
         scl = 1'b1;
         tick();
         if (i > 0) r[i-1] = sda;
         else ack = !sda;
         tick();
         scl = 1'b0;
         tick();
      end
   endtask : xfer
endmodule : cic_host_model

// ===== hdl/cic_charger_i2c_control.sv
/*
 * serial control port and mode logic of a single-cell charger: a
 * two-wire bus slave with a small register file that drives the
 * operating mode, input voltage floor and charge current selection.
 * assumes an external pull-up on scl and sda and an analog comparator
 * that flags a deeply discharged battery.
 */
// Operation
// RULE1 - the port answers as a bus slave at seven-bit address 1101010.
// RULE2 - the master opens with start, then the address and a direction bit.
// RULE3 - in a write the second byte picks a register and the third fills it.
// RULE4 - charge, boost and high impedance modes exist, the last halting both.
// RULE5 - the host must program the charge current, never chosen locally.
// RULE6 - a three-bit field at index 0x11 sets the floor from 4.1 V to 4.7 V.
// RULE7 - input voltage floor regulation runs only while its enable is set.
// RULE8 - below 2.4 V a fixed 60 mA wake current is used, then the set one.
// RULE9 - address and bytes are acked; reads return the indexed register.
`timescale 1ns/1ns
module cic_charger_i2c_control (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial bus, open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // battery comparator, high while below the wake threshold
   input wire logic batt_low_i,
   // mode and regulation controls
   output logic charge_en,
   output logic boost_en,
   output logic hiz_en,
   output logic [2:0] input_voltage_floor,
   output logic input_voltage_floor_en,
   output logic [2:0] chg_current_code,
   output logic wake_current_en
);

   typedef struct packed {
      cic_pkg::cic_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic rw;
      logic [7:0] idx;
      logic sda_oe;
      logic scl_q;
      logic sda_q;
      logic [cic_pkg::NUM_REG-1:0][7:0] regs;
      logic charge_en;
      logic boost_en;
      logic hiz_en;
      logic [2:0] floor_code;
      logic floor_en;
      logic [2:0] chg_code;
      logic wake_en;
   } cic_top_state_t;

   cic_top_state_t s;
   cic_top_state_t next_s;
   logic scl;
   logic sda;
   logic batt_low;

   cic_sync #(.RESET_VAL(1'b1)) u_scl_sync (
      .clk(clk),
      .rst(rst),
      .din(scl_i),
      .dout(scl)
   );

   cic_sync #(.RESET_VAL(1'b1)) u_sda_sync (
      .clk(clk),
      .rst(rst),
      .din(sda_i),
      .dout(sda)
   );

   cic_sync #(.RESET_VAL(1'b0)) u_batt_sync (
      .clk(clk),
      .rst(rst),
      .din(batt_low_i),
      .dout(batt_low)
   );

   ////////////////////////////////////////////////////////////////////////

   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;
   logic idx_ok;
   logic [7:0] rd_byte;
   logic [7:0] mode_reg;
   logic [7:0] floor_reg;
   logic [7:0] chg_reg;

   assign rise = scl & ~s.scl_q;
   assign fall = ~scl & s.scl_q;
   assign start_c = scl & s.scl_q & s.sda_q & ~sda;
   assign stop_c = scl & s.scl_q & ~s.sda_q & sda;
   assign idx_ok = s.idx < 8'(cic_pkg::NUM_REG);
   // unmapped indices read as zero
   assign rd_byte = idx_ok ? s.regs[s.idx[cic_pkg::IDX_W-1:0]] : 8'h00;
   assign mode_reg = s.regs[cic_pkg::REG_MODE[cic_pkg::IDX_W-1:0]];
   assign floor_reg =
      s.regs[cic_pkg::REG_INPUT_VOLTAGE_FLOOR_CTRL[cic_pkg::IDX_W-1:0]];
   assign chg_reg = s.regs[cic_pkg::REG_CHG_CURRENT[cic_pkg::IDX_W-1:0]];

   always_comb begin
      next_s = s;
      next_s.scl_q = scl;
      next_s.sda_q = sda;
      if (start_c) begin
         // a repeated start aborts whatever byte was in flight
         next_s.st = cic_pkg::ST_ADDR; // [RULE2]
         next_s.bitcnt = 4'h0;
         next_s.sda_oe = 1'b0;
      end else if (stop_c) begin
         next_s.st = cic_pkg::ST_IDLE;
         next_s.sda_oe = 1'b0;
      end else begin
         case (s.st)
            cic_pkg::ST_ADDR, cic_pkg::ST_IDX, cic_pkg::ST_WDATA: begin
               if (rise && s.bitcnt != cic_pkg::BYTE_BITS) begin
                  next_s.shift = {s.shift[6:0], sda};
                  next_s.bitcnt = s.bitcnt + 4'h1;
               end else if (fall && s.bitcnt == cic_pkg::BYTE_BITS) begin
                  next_s.bitcnt = 4'h0;
                  next_s.sda_oe = 1'b1; // [RULE9]
                  if (s.st == cic_pkg::ST_ADDR) begin
                     if (s.shift[7:1] == cic_pkg::DEV_ADDR) begin // [RULE1]
                        next_s.rw = s.shift[0];
                        next_s.st = cic_pkg::ST_ACK_ADDR;
                     end else begin
                        next_s.sda_oe = 1'b0;
                        next_s.st = cic_pkg::ST_IDLE;
                     end
                  end else if (s.st == cic_pkg::ST_IDX) begin
                     next_s.idx = s.shift; // [RULE3]
                     next_s.st = cic_pkg::ST_ACK_IDX;
                  end else begin
                     if (idx_ok) begin // [RULE3]
                        next_s.regs[s.idx[cic_pkg::IDX_W-1:0]] = s.shift;
                     end
                     // bursts walk through consecutive registers
                     next_s.idx = s.idx + 8'h01;
                     next_s.st = cic_pkg::ST_ACK_W;
                  end
               end
            end
            cic_pkg::ST_ACK_ADDR: begin
               if (fall) begin
                  next_s.bitcnt = 4'h0;
                  if (s.rw) begin
                     next_s.shift = rd_byte; // [RULE9]
                     next_s.sda_oe = ~rd_byte[7];
                     next_s.st = cic_pkg::ST_RDATA;
                  end else begin
                     next_s.sda_oe = 1'b0;
                     next_s.st = cic_pkg::ST_IDX;
                  end
               end
            end
            cic_pkg::ST_ACK_IDX, cic_pkg::ST_ACK_W: begin
               if (fall) begin
                  next_s.sda_oe = 1'b0;
                  next_s.st = cic_pkg::ST_WDATA;
               end
            end
            cic_pkg::ST_RDATA: begin
               if (rise && s.bitcnt == cic_pkg::BYTE_BITS) begin
                  // master acknowledge bit: low asks for the next byte
                  if (sda) begin
                     next_s.st = cic_pkg::ST_IDLE;
                  end else begin
                     next_s.idx = s.idx + 8'h01;
                     next_s.st = cic_pkg::ST_ACK_ADDR;
                  end
               end else if (rise) begin
                  next_s.bitcnt = s.bitcnt + 4'h1;
               end else if (fall && s.bitcnt == cic_pkg::BYTE_BITS) begin
                  next_s.sda_oe = 1'b0;
               end else if (fall) begin
                  next_s.shift = {s.shift[6:0], 1'b0};
                  next_s.sda_oe = ~s.shift[6];
               end
            end
            default: begin
               next_s.sda_oe = 1'b0;
            end
         endcase
      end

      // high impedance overrides both power paths
      next_s.hiz_en = mode_reg[cic_pkg::MODE_HIZ_BIT]; // [RULE4]
      next_s.boost_en = ~mode_reg[cic_pkg::MODE_HIZ_BIT] &
                        mode_reg[cic_pkg::MODE_BOOST_BIT]; // [RULE4]
      next_s.charge_en = ~mode_reg[cic_pkg::MODE_HIZ_BIT] &
                         ~mode_reg[cic_pkg::MODE_BOOST_BIT]; // [RULE4]
      // code 7 has no level above 4.7 V, so it clamps
      next_s.floor_code =
         (floor_reg[cic_pkg::FLOOR_CODE_LSB+:3] > cic_pkg::FLOOR_CODE_MAX) ?
         cic_pkg::FLOOR_CODE_MAX :
         floor_reg[cic_pkg::FLOOR_CODE_LSB+:3]; // [RULE6]
      next_s.floor_en = floor_reg[cic_pkg::FLOOR_EN_BIT]; // [RULE7]
      // the current code is only ever what the host wrote
      next_s.chg_code = chg_reg[cic_pkg::CHG_CODE_LSB+:3]; // [RULE5]
      next_s.wake_en = batt_low & next_s.charge_en; // [RULE8]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.st <= cic_pkg::ST_IDLE;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe = s.sda_oe;
   assign charge_en = s.charge_en;
   assign boost_en = s.boost_en;
   assign hiz_en = s.hiz_en;
   assign input_voltage_floor = s.floor_code;
   assign input_voltage_floor_en = s.floor_en;
   assign chg_current_code = s.chg_code;
   assign wake_current_en = s.wake_en;

   ////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence addr_byte_done;
      s.st == cic_pkg::ST_ADDR && fall && !start_c && !stop_c &&
      s.bitcnt == cic_pkg::BYTE_BITS;
   endsequence

   addr_ack_a: assert property ( // [RULE1]
      addr_byte_done and (s.shift[7:1] == cic_pkg::DEV_ADDR) |=> sda_oe)
      else $error("own address not acknowledged");

   addr_ignore_a: assert property ( // [RULE1]
      addr_byte_done and (s.shift[7:1] != cic_pkg::DEV_ADDR) |=>
      (!sda_oe) [*2])
      else $error("foreign address acknowledged");

   reg_write_a: assert property ( // [RULE3]
      s.st == cic_pkg::ST_WDATA && fall && !start_c && !stop_c &&
      s.bitcnt == cic_pkg::BYTE_BITS && idx_ok |=>
      s.regs[$past(s.idx[cic_pkg::IDX_W-1:0])] == $past(s.shift) &&
      s.idx == $past(s.idx) + 8'h01)
      else $error("write byte not stored");

   hiz_halt_a: assert property ( // [RULE4]
      mode_reg[cic_pkg::MODE_HIZ_BIT] |=> hiz_en && !charge_en && !boost_en)
      else $error("power path active in high impedance");

   // code 7 must clamp to the top level, never wrap
   floor_code_a: assert property ( // [RULE6]
      1'b1 |=> input_voltage_floor ==
      (($past(floor_reg[2:0]) > cic_pkg::FLOOR_CODE_MAX) ?
      cic_pkg::FLOOR_CODE_MAX : $past(floor_reg[2:0])))
      else $error("floor code mismatch");

   floor_en_a: assert property ( // [RULE7]
      $changed(floor_reg[cic_pkg::FLOOR_EN_BIT]) |=>
      input_voltage_floor_en == $past(floor_reg[cic_pkg::FLOOR_EN_BIT]))
      else $error("floor enable not followed");

   wake_cur_a: assert property ( // [RULE8]
      1'b1 |=> wake_current_en == $past(batt_low &&
      !mode_reg[cic_pkg::MODE_HIZ_BIT] && !mode_reg[cic_pkg::MODE_BOOST_BIT]))
      else $error("wake current selection wrong");

   read_data_a: assert property ( // [RULE9]
      s.st == cic_pkg::ST_ACK_ADDR && s.rw && fall && !start_c && !stop_c
      |=> sda_oe == !$past(rd_byte[7]) && s.shift == $past(rd_byte))
      else $error("read byte not presented");

   byte_ack_a: assert property ( // [RULE9]
      s.st == cic_pkg::ST_IDX && fall && !start_c && !stop_c &&
      s.bitcnt == cic_pkg::BYTE_BITS |=>
      sda_oe && s.st == cic_pkg::ST_ACK_IDX)
      else $error("index byte not acknowledged");

endmodule : cic_charger_i2c_control

// ===== hdl/cic_pkg.sv
/*
 * constants, register layout and state encoding for the charger
 * control port.
 * assumes a single 250 mhz clock domain for all users.
 */
package cic_pkg;

   // bus address of this port, seven bits
   localparam logic [6:0] DEV_ADDR = 7'h6a;

   // register storage
   localparam int NUM_REG = 32;
   localparam int IDX_W = 5;
   localparam logic [7:0] REG_RESET = 8'h00;

   // register indices
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_CHG_CURRENT = 8'h06;
   localparam logic [7:0] REG_INPUT_VOLTAGE_FLOOR_CTRL = 8'h11;

   // mode register fields
   localparam int MODE_BOOST_BIT = 0;
   localparam int MODE_HIZ_BIT = 1;

   // charge current register field, three bits
   localparam int CHG_CODE_LSB = 4;

   // floor control fields: code 0..6 is 4.1 V..4.7 V in 0.1 V steps
   localparam int FLOOR_CODE_LSB = 0;
   localparam int FLOOR_EN_BIT = 3;
   localparam logic [2:0] FLOOR_CODE_MAX = 3'h6;

   // bits per byte on the serial bus
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_IDX,
      ST_ACK_IDX,
      ST_WDATA,
      ST_ACK_W,
      ST_RDATA
   } cic_state_t;

endpackage : cic_pkg

// ===== hdl/cic_sync.sv
/*
 * three-stage input synchroniser with agreement filter.
 * assumes an asynchronous level input and one clock domain.
 */
`timescale 1ns/1ns
module cic_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // level in and filtered level out
   input wire logic din,
   output logic dout
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } cic_sync_state_t;

   cic_sync_state_t s;
   cic_sync_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = din;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // a change only counts once the last two stages agree
      if (s.s2 == s.s3) begin
         next_s.level = s.s3;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= {4{RESET_VAL}};
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.level;

endmodule : cic_sync
